// ===== core/wdts_top.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// - select field is control bit 5 over control bits 2:0
// - select field sets the period whenever the timer runs
// - codes 0 to 9 count 2048 doubling to 1048576 oscillator cycles
// - reserved codes 10 to 15 fall back to a valid code
// - watchdog reset uses the common reset vector 0x0000
// - both enables clear stops; irq enable interrupts; enable resets; both interrupt first
// - unlock needed to change select or clear enable; self-clears after four cycles
// - time-out with enable set clears irq enable so next time-out resets
// - flag set on interrupt time-out; cleared by vector ack or write one
module wdts_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dog_osc,
  input wire logic vector_ack,
  output logic timeout_irq_req,
  output logic sys_reset_req,
  output logic [15:0] reset_vector,
  output logic irq
);

  wdts_cnt_if cif ();

  logic osc_rise;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic flag_reg;
  logic flag_next;
  logic irq_en_reg;
  logic irq_en_next;
  logic enable_reg;
  logic enable_next;
  logic [3:0] sel_reg;
  logic [3:0] sel_next;
  logic unlock_reg;
  logic [2:0] unlock_cnt_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic sys_reset_reg;
  logic [15:0] reset_vector_reg;
  logic vec_req_reg;
  logic irq_reg;

  // ---------------------------------------------------------------
  // oscillator pin sync and counter
  // ---------------------------------------------------------------
  wdts_osc_sync u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .osc_pin(dog_osc),
    .osc_rise(osc_rise)
  );

  wdts_counter u_counter
  (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  // counter runs while either enable is set
  assign cif.run = enable_reg | irq_en_reg;
  assign cif.sel = wdts_pkg::fold_sel(sel_reg);
  assign cif.tick = osc_rise;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic access = psel & penable;
  wire logic done = access & pready_reg;
  wire logic hit_ctrl = (paddr == wdts_pkg::CTRL_OFFSET);
  wire logic hit_status = (paddr == wdts_pkg::STATUS_OFFSET);
  wire logic hit_mask = (paddr == wdts_pkg::MASK_OFFSET);
  wire logic hit_any = hit_ctrl | hit_status | hit_mask;
  wire logic wr_ctrl = done & pwrite & hit_ctrl;
  wire logic wr_mask = done & pwrite & hit_mask;
  wire logic rd_status = done & ~pwrite & hit_status;

  // control word as software sees it
  wire logic [7:0] ctrl_view = {flag_reg, irq_en_reg, sel_reg[3], unlock_reg,
                                enable_reg, sel_reg[2:0]};
  wire logic [31:0] rd_word = hit_ctrl ? {24'h000000, ctrl_view} :
                              hit_status ? {30'h00000000, status_reg} :
                              hit_mask ? {30'h00000000, mask_reg} : 32'h00000000;

  // ---------------------------------------------------------------
  // time-out actions
  // ---------------------------------------------------------------
  wire logic tmo = cif.timeout;
  wire logic tmo_irq = tmo & irq_en_reg;
  wire logic tmo_rst = tmo & enable_reg & ~irq_en_reg;
  // arming needs unlock and enable written together
  wire logic arm_unlock = wr_ctrl & pwdata[wdts_pkg::UNLOCK_BIT] &
                          pwdata[wdts_pkg::ENABLE_BIT];
  wire logic [1:0] events = {tmo_rst, tmo_irq};

  // ---------------------------------------------------------------
  // control next-state
  // ---------------------------------------------------------------
  always_comb
  begin
    flag_next = flag_reg;
    if (vector_ack)
      flag_next = 1'b0;
    if (wr_ctrl && pwdata[wdts_pkg::FLAG_BIT])
      flag_next = 1'b0;
    if (tmo_irq)
      flag_next = 1'b1;

    irq_en_next = irq_en_reg;
    if (wr_ctrl)
      irq_en_next = pwdata[wdts_pkg::IRQ_EN_BIT];
    if (tmo && enable_reg && irq_en_reg)
      irq_en_next = 1'b0;

    // setting enable is free, clearing it needs the unlock window
    enable_next = enable_reg;
    if (wr_ctrl && pwdata[wdts_pkg::ENABLE_BIT])
      enable_next = 1'b1;
    else if (wr_ctrl && unlock_reg)
      enable_next = 1'b0;

    sel_next = sel_reg;
    if (wr_ctrl && unlock_reg)
      sel_next = {pwdata[wdts_pkg::SEL_MSB_BIT], pwdata[wdts_pkg::SEL_LO_TOP:0]};
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_reg <= wdts_pkg::CTRL_RESET[wdts_pkg::FLAG_BIT];
      irq_en_reg <= wdts_pkg::CTRL_RESET[wdts_pkg::IRQ_EN_BIT];
      enable_reg <= wdts_pkg::CTRL_RESET[wdts_pkg::ENABLE_BIT];
      sel_reg <= 4'h0;
    end
    else
    begin
      flag_reg <= flag_next;
      irq_en_reg <= irq_en_next;
      enable_reg <= enable_next;
      sel_reg <= sel_next;
    end
  end

  // ---------------------------------------------------------------
  // unlock window, four pclk cycles from the arming write
  // ---------------------------------------------------------------
  // re-arming inside the window restarts it; only repeated arming writes hold it open longer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unlock_reg <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end
    else if (arm_unlock)
    begin
      unlock_reg <= 1'b1;
      unlock_cnt_reg <= wdts_pkg::UNLOCK_CYCLES;
    end
    else if (unlock_cnt_reg != 3'h0)
    begin
      unlock_reg <= (unlock_cnt_reg != 3'h1);
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // event status, clear on read, set wins
  // ---------------------------------------------------------------
  // only the bits actually returned are cleared, so a late event survives
  always_comb
  begin
    status_next = status_reg;
    if (rd_status)
      status_next = status_reg & ~prdata_reg[wdts_pkg::EVT_W-1:0];
    status_next = status_next | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= wdts_pkg::EVT_RESET;
      mask_reg <= wdts_pkg::EVT_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      if (wr_mask)
        mask_reg <= pwdata[wdts_pkg::EVT_W-1:0];
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // reset request and interrupt request outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_reset_reg <= 1'b0;
      reset_vector_reg <= wdts_pkg::RESET_VECTOR;
      vec_req_reg <= 1'b0;
    end
    else
    begin
      sys_reset_reg <= tmo_rst;
      if (tmo_rst)
        reset_vector_reg <= wdts_pkg::RESET_VECTOR;
      vec_req_reg <= flag_next;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: one wait state, error on unmapped offsets
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~hit_any;
      if (access && !pready_reg)
        prdata_reg <= pwrite ? 32'h00000000 : rd_word;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timeout_irq_req = vec_req_reg;
  assign sys_reset_req = sys_reset_reg;
  assign reset_vector = reset_vector_reg;
  assign irq = irq_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_unlock_armed: assert property (@(posedge pclk) disable iff (!presetn)
    arm_unlock |=> unlock_reg && (unlock_cnt_reg == 3'h4))
    else $error("unlock not armed by write");

  a_unlock_expire: assert property (@(posedge pclk) disable iff (!presetn)
    (unlock_cnt_reg == 3'h1) && !arm_unlock |=> !unlock_reg)
    else $error("unlock outlived its window");

  a_sel_locked: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && !unlock_reg |=> $stable(sel_reg))
    else $error("select changed without unlock");

  a_enable_kept: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && !unlock_reg && enable_reg |=> enable_reg)
    else $error("enable cleared without unlock");

  a_sel_field: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && unlock_reg |=> sel_reg == {$past(pwdata[5]), $past(pwdata[2:0])})
    else $error("select field misassembled");

  a_reserved_fold: assert property (@(posedge pclk) disable iff (!presetn)
    sel_reg > 4'h9 |-> cif.sel == 4'h9)
    else $error("reserved code not folded");

  a_ie_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    tmo && enable_reg && irq_en_reg |=> !irq_en_reg && flag_reg && timeout_irq_req)
    else $error("interrupt-first sequence broken");

  a_reset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_rst |=> sys_reset_req && (reset_vector == 16'h0000) ##1 !sys_reset_req)
    else $error("reset request wrong");

  a_flag_wins: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_irq |=> flag_reg)
    else $error("time-out flag lost");

endmodule // wdts_top

// ===== common/wdts_pkg.sv
package wdts_pkg;

  // ---------------------------------------------------------------
  // bus geometry and register offsets
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;

  // ---------------------------------------------------------------
  // control register layout
  // ---------------------------------------------------------------
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int SEL_MSB_BIT = 5;
  localparam int UNLOCK_BIT = 4;
  localparam int ENABLE_BIT = 3;
  localparam int SEL_LO_TOP = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // event status layout
  // ---------------------------------------------------------------
  localparam int EVT_W = 2;
  localparam int EVT_TIMEOUT_IRQ = 0;
  localparam int EVT_SYS_RESET = 1;
  localparam logic [1:0] EVT_RESET = 2'h0;

  // ---------------------------------------------------------------
  // timing and vectors
  // ---------------------------------------------------------------
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_MAX_VALID = 4'h9;
  localparam int CNT_W = 21;
  localparam logic [20:0] BASE_CYCLES = 21'h000800;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // reserved codes fall back to the longest valid period
  function automatic logic [3:0] fold_sel(input logic [3:0] code);
    fold_sel = (code > SEL_MAX_VALID) ? SEL_MAX_VALID : code;
  endfunction

  // last count value of a period: 2048 << sel, minus one
  function automatic logic [20:0] period_last(input logic [3:0] sel);
    period_last = (BASE_CYCLES << fold_sel(sel)) - 21'h000001;
  endfunction

endpackage

// ===== common/wdts_cnt_if.sv
`timescale 1ns/1ns
interface wdts_cnt_if;
  logic run;
  logic [3:0] sel;
  logic tick;
  logic timeout;

  modport ctl (output run, output sel, output tick, input timeout);
  modport cnt (input run, input sel, input tick, output timeout);
endinterface

// ===== core/wdts_osc_sync.sv
`timescale 1ns/1ns
module wdts_osc_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_pin,
  output logic osc_rise
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic rise_reg;

  // ---------------------------------------------------------------
  // two-stage sync, then edge detect on the settled stage only
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      rise_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= osc_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      rise_reg <= sync_reg & ~prev_reg;
    end
  end

  assign osc_rise = rise_reg;

endmodule // wdts_osc_sync

// ===== core/wdts_counter.sv
`timescale 1ns/1ns
module wdts_counter
(
  input wire logic pclk,
  input wire logic presetn,
  wdts_cnt_if.cnt cif
);

  logic [20:0] count_reg;
  logic [20:0] count_next;
  logic timeout_reg;
  wire logic at_last;

  // ---------------------------------------------------------------
  // oscillator cycle counter
  // ---------------------------------------------------------------
  assign at_last = (count_reg >= wdts_pkg::period_last(cif.sel));

  // a shortened period never strands the count above its end
  always_comb
  begin
    if (!cif.run)
      count_next = '0;
    else if (cif.tick && at_last)
      count_next = '0;
    else if (cif.tick)
      count_next = count_reg + 21'h000001;
    else
      count_next = count_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= '0;
      timeout_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      timeout_reg <= cif.run & cif.tick & at_last;
    end
  end

  assign cif.timeout = timeout_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_restart_zero: assert property (@(posedge pclk) disable iff (!presetn)
    timeout_reg |-> count_reg == 21'h000000)
    else $error("count did not restart after time-out");

  a_stopped_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !cif.run |=> (count_reg == 21'h000000) && !timeout_reg)
    else $error("stopped timer still counting");

endmodule // wdts_counter

// ===== dv/wdts_top_tb.sv
`timescale 1ns/1ns
module wdts_top_tb;
  // ---------------------------------------------------------------
  // stimulus, observation and bookkeeping
  // ---------------------------------------------------------------
  localparam int P0 = 8192; // 2048 oscillator edges, four pclk each
  localparam logic [7:0] CA = wdts_pkg::CTRL_OFFSET;
  localparam logic [7:0] SA = wdts_pkg::STATUS_OFFSET;
  localparam logic [7:0] MA = wdts_pkg::MASK_OFFSET;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic dog_osc = 1'b0;
  logic vector_ack = 1'b0;
  logic [1:0] osc_div = 2'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timeout_irq_req;
  logic sys_reset_req;
  logic [15:0] reset_vector;
  logic irq;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int resets_seen = 0;

  wdts_top i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dog_osc(dog_osc), .vector_ack(vector_ack),
    .timeout_irq_req(timeout_irq_req), .sys_reset_req(sys_reset_req),
    .reset_vector(reset_vector), .irq(irq)
  );

  // 20 MHz system clock
  always #25 pclk = ~pclk;

  // oscillator at a quarter of pclk: half the fastest rate the synchroniser accepts
  always @(posedge pclk)
  begin
    osc_div <= osc_div + 2'h1;
    dog_osc <= osc_div[1];
  end

  // cycle stamp and a tally of reset requests
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (sys_reset_req === 1'b1)
      resets_seen <= resets_seen + 1;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input string what);
    n_compared++;
    if (got < exp - 12 || got > exp + 12)
    begin
      errors++;
      $display("[ERR] %0t %s: %0d cycles, want %0d", $time, what, got, exp);
    end
  endtask

  // entered just after an edge; chain keeps psel up for a back-to-back setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input bit chain, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    check({31'h0, pready}, 32'h00000001, "apb answer");
    penable <= 1'b0;
    if (!chain)
    begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit chain = 1'b0);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, chain, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h00000000, 1'b0, rd, err);
    check(rd, exp, what);
  endtask

  // wait for the irq request (which 0) or the reset pulse (which 1)
  task automatic wait_hi(input int which, input int lim, output int at);
    int n;
    n = 0;
    while (((which == 0) ? timeout_irq_req : sys_reset_req) !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    at = cyc;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idle();
    logic [31:0] d;
    logic e;
    rd_chk(CA, 32'h00000000, "ctrl after reset");
    rd_chk(SA, 32'h00000000, "status after reset");
    rd_chk(MA, 32'h00000000, "mask after reset");
    check({16'h0000, reset_vector}, 32'h00000000, "reset vector");
    apb(1'b0, 8'h0C, 32'h00000000, 1'b0, d, e);
    check({31'h0, e}, 32'h00000001, "unmapped error");
    // both enables clear: no time-out over more than a period
    repeat (P0 + 800) @(posedge pclk);
    check({30'h0, timeout_irq_req, sys_reset_req}, 32'h00000000, "stopped");
    check(32'(resets_seen), 32'h00000000, "stopped resets");
  endtask

  task automatic t_unlock();
    wr(CA, 32'h0000000B); // enable plus select 3, no unlock
    rd_chk(CA, 32'h00000008, "select locked");
    wr(CA, 32'h00000000);
    rd_chk(CA, 32'h00000008, "enable clear locked");
    wr(CA, 32'h00000018, 1'b1);
    wr(CA, 32'h00000021, 1'b1); // select 1001, enable off, inside window
    rd_chk(CA, 32'h00000021, "select msb at bit 5");
    wr(CA, 32'h00000039, 1'b1);
    rd_chk(CA, 32'h00000039, "unlock visible");
    rd_chk(CA, 32'h00000029, "unlock self clear");
    wr(CA, 32'h00000000); // window closed
    rd_chk(CA, 32'h00000029, "late change refused");
    wr(CA, 32'h00000018, 1'b1);
    wr(CA, 32'h00000000);
    rd_chk(CA, 32'h00000000, "disabled, select 0");
  endtask

  task automatic t_irq_mode();
    int t0;
    int t1;
    int t2;
    wr(MA, 32'h00000001);
    wr(CA, 32'h00000040);
    t0 = cyc;
    wait_hi(0, P0 + 100, t1);
    near(t1 - t0, P0, "first irq time-out");
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h00000001, "irq raised");
    rd_chk(CA, 32'h000000C0, "flag set");
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    rd_chk(CA, 32'h00000040, "flag cleared by vector");
    rd_chk(SA, 32'h00000001, "status irq event");
    rd_chk(SA, 32'h00000000, "status cleared by read");
    check({31'h0, irq}, 32'h00000000, "irq dropped");
    wait_hi(0, P0 + 100, t2);
    near(t2 - t1, P0, "irq spacing");
    wr(CA, 32'h000000C0); // write one to the flag
    rd_chk(CA, 32'h00000040, "flag cleared by write");
    wr(MA, 32'h00000000);
    // irq is registered one edge behind the mask
    @(posedge pclk);
    check({31'h0, irq}, 32'h00000000, "irq masked");
    wr(MA, 32'h00000001);
    @(posedge pclk);
    check({31'h0, irq}, 32'h00000001, "irq unmasked");
    wr(CA, 32'h00000000);
    rd_chk(SA, 32'h00000001, "status pending");
    check(32'(resets_seen), 32'h00000000, "no reset in irq mode");
  endtask

  task automatic t_both();
    int t1;
    int t2;
    wr(CA, 32'h00000048);
    wait_hi(0, P0 + 100, t1);
    check(32'(resets_seen), 32'h00000000, "interrupt comes first");
    rd_chk(CA, 32'h00000088, "irq enable auto cleared");
    wr(CA, 32'h00000088);
    rd_chk(SA, 32'h00000001, "status first event");
    wait_hi(1, P0 + 100, t2);
    near(t2 - t1, P0, "reset follows");
    check({16'h0000, reset_vector}, 32'h00000000, "reset vector");
    rd_chk(SA, 32'h00000002, "status reset event");
    check(32'(resets_seen), 32'h00000001, "one reset");
    wr(CA, 32'h00000018, 1'b1);
    wr(CA, 32'h00000000);
  endtask

  task automatic t_sel1();
    int t0;
    int t1;
    wr(CA, 32'h00000018, 1'b1);
    wr(CA, 32'h00000009); // select 1 with enable
    t0 = cyc;
    wait_hi(1, 2 * P0 + 100, t1);
    near(t1 - t0, 2 * P0, "select 1 doubles");
    wr(CA, 32'h00000018, 1'b1);
    wr(CA, 32'h00000000);
  endtask

  task automatic t_reserved();
    int t1;
    int n0;
    logic [31:0] v;
    for (int c = 10; c < 16; c++)
    begin
      v = {26'h0, c[3], 2'h1, c[2:0]}; // reserved code with enable set
      wr(CA, 32'h00000018, 1'b1);
      wr(CA, v & 32'hFFFFFFEF);
      rd_chk(CA, v & 32'hFFFFFFEF, "reserved code kept");
    end
    n0 = resets_seen;
    wait_hi(1, 2 * P0 + 400, t1);
    check(32'(resets_seen - n0), 32'h00000000, "reserved not short");
    wr(CA, 32'h00000018, 1'b1);
    wr(CA, 32'h00000000);
  endtask

  // ---------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // the sequence needs about 80000 cycles; cut a hang at 100000
  initial
  begin
    #(100000 * 50);
    errors++;
    conclude();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_idle();
    t_unlock();
    t_irq_mode();
    t_both();
    t_sel1();
    t_reserved();
    conclude();
  end
endmodule // wdts_top_tb
